// >>> tb/imc_slave_model.sv
// model of the addressed two-wire slave: acknowledges each byte it sees
`timescale 1ns/10ps
module imc_slave_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic ack_en,
  output logic      sda_pull_n
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] cnt_q;
  // ------------------------------------------------------------
  // bit count on scl falls, pull sda in the ninth slot
  // ------------------------------------------------------------
  // sampled with the bench clock, so it answers one cycle late
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      cnt_q      <= 4'h0;
      sda_pull_n <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda) begin
        // primed so the fall that opens the first bit counts as zero
        cnt_q <= 4'hf;
      end else if (scl_q && !scl) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == 4'h7) begin
          sda_pull_n <= !ack_en;
        end
        if (cnt_q == 4'h8) begin
          sda_pull_n <= 1'b1;
          cnt_q      <= 4'h0;
        end
      end
    end
  end
endmodule // imc_slave_model

// >>> tb/testbench.sv
// self-checking bench of the command controller with a slave model
`timescale 1ns/10ps
module testbench
  import imc_pkg::*;
;
  logic              clk;
  logic              rst_n;
  logic [AW-1:0]     bus_addr;
  logic [31:0]       bus_wdata;
  logic              bus_we;
  logic              bus_re;
  logic [31:0]       bus_rdata;
  logic              scl_out;
  logic              scl_oe_n;
  logic              sda_out;
  logic              sda_oe_n;
  logic              irq;
  logic              sda_pull_n;
  logic              dbg;
  logic              scl_w;
  logic              sda_w;
  logic              re_q;
  logic [8:0]        sh;
  logic [31:0]       seed;
  logic [31:0]       r;
  logic [31:0]       exp_q[$];
  int                error_cnt;
  int                checks_done;
  int                n;
  // ------------------------------------------------------------
  // open drain wires with pull-ups
  // ------------------------------------------------------------
  assign scl_w = scl_oe_n ? 1'b1 : scl_out;
  assign sda_w = (sda_oe_n ? 1'b1 : sda_out) & sda_pull_n;
  imc_top dut_u (
    .clk       (clk),
    .rst_n     (rst_n),
    .bus_addr  (bus_addr),
    .bus_wdata (bus_wdata),
    .bus_we    (bus_we),
    .bus_re    (bus_re),
    .bus_rdata (bus_rdata),
    .scl_in    (scl_w),
    .scl_out   (scl_out),
    .scl_oe_n  (scl_oe_n),
    .sda_in    (sda_w),
    .sda_out   (sda_out),
    .sda_oe_n  (sda_oe_n),
    .debug_halt(dbg),
    .irq       (irq)
  );
  imc_slave_model slv_u (
    .clk       (clk),
    .rst_n     (rst_n),
    .scl       (scl_w),
    .sda       (sda_w),
    .ack_en    (1'b1),
    .sda_pull_n(sda_pull_n)
  );
  always #50 clk = ~clk;
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, s, e);
    end
  endtask
  // strobes are set by every bus task, so no signal is assigned twice per step
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    bus_addr  <= {i, 2'b00};
    bus_wdata <= d;
    bus_we    <= 1'b1;
    bus_re    <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] e);
    exp_q.push_back(e);
    bus_addr <= {i, 2'b00};
    bus_we   <= 1'b0;
    bus_re   <= 1'b1;
    @(posedge clk);
  endtask
  task automatic nop();
    bus_we <= 1'b0;
    bus_re <= 1'b0;
    @(posedge clk);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // read data watcher, bit capture on scl rises
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (re_q) begin
      chk(bus_rdata, exp_q.pop_front());
    end
    re_q <= bus_re;
  end
  always @(posedge scl_w) begin
    sh <= {sh[7:0], sda_w};
  end
  initial begin
    #(3000 * 100);
    error_cnt++;
    test_done();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0; rst_n = 1'b0; bus_addr = '0; bus_wdata = '0;
    bus_we = 1'b0; bus_re = 1'b0; re_q = 1'b0; sh = '0; dbg = 1'b0;
    seed = 32'd93054; error_cnt = 0; checks_done = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(IDX_CMDCTRL, 32'h0);
    rd(IDX_DBG, 32'h0);
    rd(IDX_RATE, 32'h0);
    rd(IDX_IENSET, 32'h0);
    rd(8'h3f, 32'h0);
    r = xs();
    wr(IDX_RATE, {16'h0, r[15:0]});
    rd(IDX_RATE, {16'h0, r[15:0]});
    wr(IDX_CMDCTRL, 32'h0007_0300);
    rd(IDX_SYNC, 32'h0);
    rd(IDX_CMDCTRL, 32'h0004_0300);
    wr(IDX_DBG, 32'h1);
    rd(IDX_DBG, 32'h1);
    wr(IDX_IENSET, 32'h3);
    rd(IDX_IENCLR, 32'h3);
    wr(IDX_IENCLR, 32'h1);
    rd(IDX_IENSET, 32'h2);
    wr(IDX_IENSET, 32'h0);
    wr(IDX_IENCLR, 32'h0);
    rd(IDX_IENCLR, 32'h2);
    wr(IDX_IENSET, 32'h1);
    wr(IDX_CMDCTRL, 32'h0);
    wr(IDX_RATE, 32'h0003);
    wr(IDX_PCTRL, 32'h2);
    wr(IDX_RATE, 32'h0505);
    rd(IDX_RATE, 32'h0003);
    wr(IDX_CMDCTRL, 32'h0004_0300);
    rd(IDX_CMDCTRL, 32'h0004_0000);
    wr(IDX_CMDCTRL, 32'h0);
    wr(IDX_ADDR, 32'h00a0);
    for (n = 0; n < 400 && irq !== 1'b1; n++) nop();
    repeat (4) nop();
    chk({31'h0, irq}, 32'h1);
    chk({23'h0, sh}, 32'h140);
    chk({31'h0, scl_w}, 32'h0);
    rd(IDX_FLAGS, 32'h1);
    wr(IDX_IENCLR, 32'h1);
    nop();
    chk({31'h0, irq}, 32'h0);
    wr(IDX_CMDCTRL, 32'h0002_0000);
    rd(IDX_SYNC, 32'h0);
    dbg <= 1'b1;
    wr(IDX_CMDCTRL, 32'h0003_0000);
    rd(IDX_SYNC, 32'h4);
    repeat (20) nop();
    chk({30'h0, scl_w, sda_w}, 32'h0);
    dbg <= 1'b0;
    repeat (60) nop();
    chk({30'h0, scl_w, sda_w}, 32'h3);
    rd(IDX_FLAGS, 32'h0);
    wr(IDX_CMDCTRL, 32'h0003_0000);
    rd(IDX_SYNC, 32'h0);
    // write leg, then a restart that reads from the same slave
    wr(IDX_ADDR, 32'h00a0);
    repeat (150) nop();
    rd(IDX_FLAGS, 32'h1);
    wr(IDX_ADDR, 32'h00a1);
    for (n = 0; n < 400 && irq !== 1'b1; n++) nop();
    repeat (4) nop();
    rd(IDX_FLAGS, 32'h2);
    rd(IDX_DATA, 32'hff);
    wr(IDX_CMDCTRL, 32'h0007_0000);
    repeat (60) nop();
    chk({30'h0, scl_w, sda_w}, 32'h3);
    repeat (4) nop();
    test_done();
  end
endmodule // testbench

// >>> verilog/imc_pkg.sv
// package: register map, field positions and state types of the command controller
package imc_pkg;
  // ------------------------------------------------------------
  // register indices, byte address is four times the index
  // ------------------------------------------------------------
  localparam int         AW          = 10;
  localparam logic [7:0] IDX_PCTRL   = 8'h00;
  localparam logic [7:0] IDX_CMDCTRL = 8'h04;
  localparam logic [7:0] IDX_DBG     = 8'h08;
  localparam logic [7:0] IDX_RATE    = 8'h0a;
  localparam logic [7:0] IDX_IENCLR  = 8'h0c;
  localparam logic [7:0] IDX_IENSET  = 8'h0d;
  localparam logic [7:0] IDX_FLAGS   = 8'h0e;
  localparam logic [7:0] IDX_STATUS  = 8'h10;
  localparam logic [7:0] IDX_ADDR    = 8'h14;
  localparam logic [7:0] IDX_DATA    = 8'h18;
  localparam logic [7:0] IDX_SYNC    = 8'h1c;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BIT_ENABLE  = 1;
  localparam int BIT_ACKSEL  = 18;
  localparam int CMD_LSB     = 16;
  localparam int BIT_QUICK   = 9;
  localparam int BIT_AUTOACK = 8;
  localparam int BIT_HALTDBG = 0;
  localparam int BIT_RB      = 1;
  localparam int BIT_WB      = 0;
  localparam int BIT_OPBUSY  = 2;
  localparam int BIT_CLKHOLD = 7;
  localparam int BIT_RXNACK  = 2;
  // ------------------------------------------------------------
  // reset values and counts
  // ------------------------------------------------------------
  localparam logic [15:0] RATE_RST = 16'h0000;
  localparam logic [1:0]  SYNC_CYC = 2'h2;
  localparam logic [3:0]  NB_TX    = 4'h9;
  localparam logic [3:0]  NB_RX    = 4'h8;
  localparam logic [3:0]  NB_ACK   = 4'h1;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_START = 3'h1, ST_BITS = 3'h3,
    ST_HOLD = 3'h2, ST_RSTART = 3'h6, ST_STOP = 3'h7
  } imc_state_e;
  typedef enum logic [1:0] {MD_TX = 2'h0, MD_RX = 2'h1, MD_ACK = 2'h2} imc_mode_e;
  typedef enum logic [1:0] {
    ACT_NONE = 2'h0, ACT_RSTART = 2'h1, ACT_READ = 2'h2, ACT_STOP = 2'h3
  } imc_act_e;
endpackage

// >>> verilog/imc_rate_gen.sv
// scl rate generator: counts the high and low phase of each scl period
`timescale 1ns/10ps
module imc_rate_gen
  import imc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  imc_rate_if.gen  rif
);
  typedef struct packed {
    logic [7:0] cnt;
  } imc_gen_s;

  imc_gen_s   s_q, s_d;
  logic [7:0] lowp;
  logic [7:0] period;

  always_comb begin
    // low field zero means the rate field sets both phases
    lowp     = (rif.rate[15:8] != 8'h00) ? rif.rate[15:8] : rif.rate[7:0];
    period   = rif.scl_level ? rif.rate[7:0] : lowp;
    // a debug halt freezes the count rather than clearing it
    rif.tick = rif.run && !rif.halt && !rif.stretch && (s_q.cnt >= period);
    s_d      = s_q;
    if (!rif.run || rif.tick) begin
      s_d.cnt = 8'h00;
    end else if (!rif.halt && !rif.stretch) begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // imc_rate_gen

// >>> verilog/imc_rate_if.sv
// interface: controls and phase tick between sequencer and scl rate generator
`timescale 1ns/10ps
interface imc_rate_if;
  logic        run;
  logic        halt;
  logic        stretch;
  logic        scl_level;
  logic        tick;
  logic [15:0] rate;
  modport ctl (output run, halt, stretch, scl_level, rate, input tick);
  modport gen (input run, halt, stretch, scl_level, rate, output tick);
endinterface

// >>> verilog/imc_sync.sv
// two flip-flop synchroniser for pin-level inputs
`timescale 1ns/10ps
module imc_sync
  import imc_pkg::*;
#(
  parameter int W = 1
)(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } imc_sync_s;

  imc_sync_s s_q, s_d;

  always_comb begin
    s_d        = s_q;
    s_d.meta   = d;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.stable;
endmodule // imc_sync

// >>> verilog/imc_top.sv
// two-wire master command controller: registers, byte sequencer, acknowledge and commands
// How it works
// - after a received byte, ack when response select is 0, nack when 1
// - ack response goes out on a command, or on a data read with auto ack
// - command field launches an operation and always reads back zero
// - ack only in read transfers; in write transfers commands give restart or stop
// - ack select written with a command is applied before that command runs
// - command 1: ack response, repeated start, then the held address
// - each issued command raises the system operation busy bit until synced
// - command 0 does nothing; command 2 reads another byte only in read direction
// - command 3: ack response, then a stop condition
// - command field and ack select stay writable while enabled
// - bit 9 enables quick command, writable only while disabled
// - with auto ack set, reading the data byte sends the ack response
// - with halt on debug set, the rate generator stops during debug halt
// - non-zero low period field sets the scl low time
// - rate field sets high time, and both times when low field is zero
// - writing 1 to enable-clear bits disables that interrupt; 0 does nothing
// - writing 1 to enable-set bits enables that interrupt; 0 does nothing
// - set and clear registers share one enable state and read it back
// - enable-protected fields accept writes only while disabled
// - read byte flag sets after a received byte and holds scl low
// - write byte flag sets after a sent byte other than an acked read address without quick command, and holds scl low
`timescale 1ns/10ps
module imc_top
  import imc_pkg::*;
#(
  parameter int DATA_W = 32
)(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [AW-1:0]     bus_addr,
  input  wire logic [DATA_W-1:0] bus_wdata,
  input  wire logic              bus_we,
  input  wire logic              bus_re,
  output logic      [DATA_W-1:0] bus_rdata,
  input  wire logic              scl_in,
  output logic                   scl_out,
  output logic                   scl_oe_n,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe_n,
  input  wire logic              debug_halt,
  output logic                   irq
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    imc_state_e        st;
    imc_mode_e         md;
    imc_act_e          act;
    logic              scl;
    logic              sda;
    logic              adr_phase;
    logic [8:0]        sh;
    logic [3:0]        nb;
    logic              en;
    logic              ack_sel;
    logic              qc;
    logic              auto_ack;
    logic              halt_dbg;
    logic [15:0]       rate;
    logic [1:0]        ien;
    logic [1:0]        flg;
    logic [7:0]        addr;
    logic [7:0]        rxd;
    logic              rxnack;
    logic [1:0]        sync_cnt;
    logic [DATA_W-1:0] rdata;
  } imc_top_s;

  localparam imc_top_s TOP_RST = '{st: ST_IDLE, md: MD_TX, act: ACT_NONE, scl: 1'b1,
                                   sda: 1'b1, sh: 9'h1ff, rate: RATE_RST, default: '0};

  imc_top_s   s_q, s_d;
  logic       scl_s, sda_s, dbg_s;
  logic       wr_cmd, wr_addr, wr_data, rd_data;
  logic       hold, rd_dir, ack_new, op_busy, tick;
  logic       cmd_go, addr_go, dwr_go, drd_go;
  logic [1:0] cmd, clr;
  logic [1:0] setf;
  logic       launch, ack_go, ack_v;
  imc_act_e   la;

  function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] idx);
    return a[AW-1:2] == idx;
  endfunction

  function automatic imc_state_e act_st(input imc_act_e a);
    case (a)
      ACT_READ:   return ST_BITS;
      ACT_RSTART: return ST_RSTART;
      ACT_STOP:   return ST_STOP;
      default:    return ST_HOLD;
    endcase
  endfunction

  // ------------------------------------------------------------
  // pins and rate generator
  // ------------------------------------------------------------
  imc_sync #(.W(3)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({debug_halt, sda_in, scl_in}),
    .q     ({dbg_s, sda_s, scl_s})
  );

  imc_rate_if rif ();

  imc_rate_gen u_rate (
    .clk   (clk),
    .rst_n (rst_n),
    .rif   (rif.gen)
  );

  assign rif.run       = s_q.en && (s_q.st != ST_IDLE) && (s_q.st != ST_HOLD);
  assign rif.halt      = s_q.halt_dbg && dbg_s;
  // a slave stretching scl keeps the high phase from counting
  assign rif.stretch   = s_q.scl && !scl_s;
  assign rif.scl_level = s_q.scl;
  assign rif.rate      = s_q.rate;
  assign tick          = rif.tick;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  assign wr_cmd  = bus_we && hit(bus_addr, IDX_CMDCTRL);
  assign wr_addr = bus_we && hit(bus_addr, IDX_ADDR);
  assign wr_data = bus_we && hit(bus_addr, IDX_DATA);
  assign rd_data = bus_re && hit(bus_addr, IDX_DATA);
  assign hold    = s_q.st == ST_HOLD;
  assign rd_dir  = s_q.addr[0];
  assign cmd     = bus_wdata[CMD_LSB+1:CMD_LSB];
  assign ack_new = wr_cmd ? bus_wdata[BIT_ACKSEL] : s_q.ack_sel;
  assign op_busy = s_q.sync_cnt != 2'h0;
  // no flag set means nothing to act on, so the command is dropped
  assign cmd_go  = wr_cmd && (cmd != ACT_NONE) && (s_q.flg != 2'h0) && hold
                   && (rd_dir || (cmd != ACT_READ));
  assign addr_go = wr_addr && s_q.en && (s_q.st == ST_IDLE || hold);
  assign dwr_go  = wr_data && hold && !rd_dir;
  assign drd_go  = rd_data && hold && rd_dir && s_q.auto_ack;
  assign clr     = ((bus_we && hit(bus_addr, IDX_FLAGS)) ? bus_wdata[1:0] : 2'h0)
                   | {2{wr_addr || dwr_go || drd_go || cmd_go}};

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_d     = s_q;
    setf    = 2'h0;
    launch  = 1'b0;
    ack_go  = 1'b0;
    ack_v   = s_q.ack_sel;
    la      = s_q.act;
    s_d.rdata = '0;

    if (bus_we && hit(bus_addr, IDX_PCTRL)) begin
      s_d.en = bus_wdata[BIT_ENABLE];
    end
    if (wr_cmd) begin
      s_d.ack_sel = bus_wdata[BIT_ACKSEL];
      if (!s_q.en) begin
        s_d.qc       = bus_wdata[BIT_QUICK];
        s_d.auto_ack = bus_wdata[BIT_AUTOACK];
      end
    end
    if (bus_we && hit(bus_addr, IDX_DBG)) begin
      s_d.halt_dbg = bus_wdata[BIT_HALTDBG];
    end
    if (bus_we && hit(bus_addr, IDX_RATE) && !s_q.en) begin
      s_d.rate = bus_wdata[15:0];
    end
    if (bus_we && hit(bus_addr, IDX_IENCLR)) begin
      s_d.ien = s_q.ien & ~bus_wdata[1:0];
    end
    if (bus_we && hit(bus_addr, IDX_IENSET)) begin
      s_d.ien = s_q.ien | bus_wdata[1:0];
    end

    case (s_q.st)
      ST_IDLE: begin
        if (addr_go) begin
          s_d.addr = bus_wdata[7:0];
          s_d.st   = ST_START;
          s_d.sda  = 1'b0;
        end
      end
      ST_START: begin
        if (tick) begin
          s_d.scl       = 1'b0;
          s_d.st        = ST_BITS;
          s_d.md        = MD_TX;
          s_d.adr_phase = 1'b1;
          s_d.sh        = {s_q.addr, 1'b1};
          s_d.nb        = NB_TX;
          s_d.sda       = s_q.addr[7];
        end
      end
      ST_BITS: begin
        if (tick && !s_q.scl) begin
          s_d.scl = 1'b1;
        end else if (tick) begin
          s_d.scl = 1'b0;
          s_d.sh  = {s_q.sh[7:0], sda_s};
          s_d.nb  = s_q.nb - 4'h1;
          s_d.sda = s_q.sh[7];
          if (s_q.nb == 4'h1) begin
            s_d.sda       = 1'b1;
            s_d.st        = ST_HOLD;
            s_d.adr_phase = 1'b0;
            case (s_q.md)
              MD_TX: begin
                s_d.rxnack = sda_s;
                // quick command stops after the address in either direction
                if (s_q.adr_phase && rd_dir && !sda_s && !s_q.qc) begin
                  launch = 1'b1;
                  la     = ACT_READ;
                end else begin
                  setf[BIT_WB] = 1'b1;
                end
              end
              MD_RX: begin
                s_d.rxd      = {s_q.sh[6:0], sda_s};
                setf[BIT_RB] = 1'b1;
              end
              default: launch = 1'b1;
            endcase
          end
        end
      end
      ST_HOLD: begin
        // scl stays driven low here until the next operation
        if (addr_go) begin
          s_d.addr = bus_wdata[7:0];
          la       = ACT_RSTART;
          ack_go   = rd_dir;
          launch   = !rd_dir;
        end else if (cmd_go) begin
          la     = imc_act_e'(cmd);
          ack_v  = ack_new;
          ack_go = rd_dir;
          launch = !rd_dir;
        end else if (dwr_go) begin
          s_d.st  = ST_BITS;
          s_d.md  = MD_TX;
          s_d.sh  = {bus_wdata[7:0], 1'b1};
          s_d.nb  = NB_TX;
          s_d.sda = bus_wdata[7];
        end else if (drd_go) begin
          la     = ACT_READ;
          ack_go = 1'b1;
        end
      end
      ST_RSTART: begin
        if (tick && !s_q.scl) begin
          s_d.scl = 1'b1;
        end else if (tick) begin
          s_d.sda = 1'b0;
          s_d.st  = ST_START;
        end
      end
      ST_STOP: begin
        if (tick && !s_q.scl) begin
          s_d.scl = 1'b1;
        end else if (tick) begin
          s_d.sda = 1'b1;
          s_d.st  = ST_IDLE;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase

    if (ack_go) begin
      s_d.st  = ST_BITS;
      s_d.md  = MD_ACK;
      s_d.act = la;
      s_d.nb  = NB_ACK;
      s_d.sh  = {ack_v, 8'hff};
      s_d.sda = ack_v;
    end
    if (launch) begin
      s_d.st  = act_st(la);
      s_d.act = la;
      s_d.md  = MD_RX;
      s_d.sh  = 9'h1ff;
      s_d.nb  = NB_RX;
      s_d.sda = la != ACT_STOP;
    end
    if (!s_q.en) begin
      s_d.st  = ST_IDLE;
      s_d.scl = 1'b1;
      s_d.sda = 1'b1;
    end

    // a flag raised in the cycle of its clear survives
    s_d.flg = (s_q.flg & ~clr) | setf;

    if (cmd_go) begin
      s_d.sync_cnt = SYNC_CYC;
    end else if (op_busy) begin
      s_d.sync_cnt = s_q.sync_cnt - 2'h1;
    end

    if (bus_re) begin
      case (bus_addr[AW-1:2])
        IDX_PCTRL:   s_d.rdata[BIT_ENABLE] = s_q.en;
        IDX_CMDCTRL: begin
          s_d.rdata[BIT_ACKSEL]  = s_q.ack_sel;
          s_d.rdata[BIT_QUICK]   = s_q.qc;
          s_d.rdata[BIT_AUTOACK] = s_q.auto_ack;
        end
        IDX_DBG:     s_d.rdata[BIT_HALTDBG] = s_q.halt_dbg;
        IDX_RATE:    s_d.rdata[15:0] = s_q.rate;
        IDX_IENCLR,
        IDX_IENSET:  s_d.rdata[1:0] = s_q.ien;
        IDX_FLAGS:   s_d.rdata[1:0] = s_q.flg;
        IDX_STATUS:  begin
          s_d.rdata[BIT_CLKHOLD] = hold;
          s_d.rdata[BIT_RXNACK]  = s_q.rxnack;
        end
        IDX_ADDR:    s_d.rdata[7:0] = s_q.addr;
        IDX_DATA:    s_d.rdata[7:0] = s_q.rxd;
        IDX_SYNC:    s_d.rdata[BIT_OPBUSY] = op_busy;
        default:     s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= TOP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // open drain: only ever pull low, release otherwise
  assign scl_out   = 1'b0;
  assign sda_out   = 1'b0;
  assign scl_oe_n  = s_q.scl;
  assign sda_oe_n  = s_q.sda;
  assign irq       = |(s_q.flg & s_q.ien);
  assign bus_rdata = s_q.rdata;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_cmd_reads_zero: assert property (bus_re && hit(bus_addr, IDX_CMDCTRL)
    |=> bus_rdata[CMD_LSB+1:CMD_LSB] == 2'h0) else $error("command field read nonzero");
  a_ien_shared: assert property (bus_re && (hit(bus_addr, IDX_IENCLR) || hit(bus_addr, IDX_IENSET))
    |=> bus_rdata[1:0] == $past(s_q.ien)) else $error("enable readback mismatch");
  a_ien_set_bits: assert property (bus_we && hit(bus_addr, IDX_IENSET)
    |=> (s_q.ien & $past(bus_wdata[1:0])) == $past(bus_wdata[1:0])) else $error("enable set lost");
  a_ien_clr_bits: assert property (bus_we && hit(bus_addr, IDX_IENCLR)
    |=> (s_q.ien & $past(bus_wdata[1:0])) == 2'h0) else $error("enable clear lost");
  a_irq_on_flag: assert property ($rose(s_q.flg[BIT_RB]) && s_q.ien[BIT_RB] |-> irq)
    else $error("irq missing for read byte flag");
  a_hold_scl_low: assert property (hold && s_q.flg != 2'h0 |-> !scl_oe_n ##1 (!scl_oe_n || !hold))
    else $error("scl released while holding");
  a_cmd_ignored: assert property (wr_cmd && hold && s_q.flg == 2'h0 && !s_q.en == 1'b0
    |=> s_q.st == ST_HOLD) else $error("command taken without flag");
  a_op_busy: assert property (cmd_go |=> op_busy [*2]) else $error("sync busy not raised");
  a_rate_protect: assert property (bus_we && hit(bus_addr, IDX_RATE) && s_q.en
    |=> $stable(s_q.rate)) else $error("rate written while enabled");
  a_ack_first: assert property (cmd_go && rd_dir |=> s_q.st == ST_BITS && s_q.md == MD_ACK
    && s_q.sda == $past(ack_new)) else $error("ack response not first");
  a_stop_write: assert property (cmd_go && cmd == ACT_STOP && !rd_dir
    |=> s_q.st == ST_STOP && !s_q.sda) else $error("stop not started");
endmodule // imc_top
